/* timer_pwm_unit.sv */
/*
 * timer_pwm_unit: counter, clock source, prescaler and channel pins.
 * Assumes plain control ports from software and pin pads outside
 * that merge gpio with the timer drive using o_pin_oe.
 */
// Behaviour
// - software picks counter clock source
// - external clock synchronised, quarter bus rate
// - external clock pin: compare still works
// - els 00 or no clock releases pin
// - center align drives all enabled pins
// - mode select picks capture, compare, pwm
// - capture mode: pin is timer input
// - els selects capture edge polarity
// - capture inputs synchronised; four-cycle pulses
// - compare mode drives pin as output
// - match toggles, clears or sets pin
// - toggle start keeps previous pin level
// - edge pwm output, low bit polarity
// - els 10: high at zero, low match
// - els x1: low at zero, high match
// - center pwm drives all enabled pins, polarity bit
// - center els 10: up clears, down sets
// - center els x1: up sets, down clears
// - one to eight channels, numbered from 1
// - clock select encoding 00..11
// - prescale divide 1 to 128
// - edge pwm period modulo plus one
// - center counter up to modulo, down
`timescale 1ns/1ps
module timer_pwm_unit import timer_pkg::*; #(
    parameter int NUM_CH = 4,
    parameter int EXT_PIN_CH = 0 // channel index sharing the clock pin
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire timer_cfg_t i_timer_cfg,
    input wire chan_cfg_t [NUM_CH-1:0] i_chan_cfg,
    input wire logic i_fixed_tick,
    input wire logic i_ext_count_clock,
    input wire logic i_counter_reset,
    input wire logic [NUM_CH-1:0] i_channel_pin,
    output logic [NUM_CH-1:0] o_channel_pin,
    output logic [NUM_CH-1:0] o_pin_oe,
    output logic [NUM_CH-1:0] o_timer_owns_pin,
    output logic [CNT_W-1:0] o_counter_value,
    output logic o_count_down,
    output logic o_overflow,
    output logic [NUM_CH-1:0] o_capture_event,
    output logic [NUM_CH-1:0] o_match_event,
    output logic [NUM_CH*CNT_W-1:0] o_captured_value
);
    // ==========================================================
    // clock source and prescaler
    // ==========================================================
    logic ext_rise;
    logic src_tick;
    logic tick;
    logic enabled;
    logic [7:0] pre_r;
    logic [7:0] pre_mask;
    logic [CNT_W-1:0] cnt_r;
    logic down_r;
    logic [CNT_W-1:0] mod_top;
    logic period_start;
    logic wrap;

    pin_sync u_ext_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_ext_count_clock),
        .o_level(),
        .o_rise(ext_rise),
        .o_fall()
    );

    assign enabled = (i_timer_cfg.clk_src != CS_NONE);

    // source select; external edges only count after two-stage sync
    always_comb begin
        case (i_timer_cfg.clk_src)
            CS_BUS: src_tick = 1'b1;
            CS_FIXED: src_tick = i_fixed_tick;
            CS_EXT: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // a new prescale code acts in the same cycle, nothing is held
    assign pre_mask = 8'((9'h001 << i_timer_cfg.prescale) - 9'h001);

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_r <= PRE_RESET;
        end else if (!enabled) begin
            pre_r <= PRE_RESET;
        end else if (src_tick) begin
            pre_r <= pre_r + 8'h01;
        end
    end

    assign tick = src_tick && ((pre_r & pre_mask) == pre_mask);

    // ==========================================================
    // counter
    // ==========================================================
    // modulo 0000 or ffff means free running
    assign mod_top = (i_timer_cfg.modulo == CNT_ZERO) ? CNT_MAX
                                                      : i_timer_cfg.modulo;
    assign wrap = tick && !i_timer_cfg.center_align && cnt_r == mod_top;

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= CNT_RESET;
            down_r <= 1'b0;
        end else if (i_counter_reset) begin
            cnt_r <= CNT_RESET;
            down_r <= 1'b0;
        end else if (tick) begin
            if (i_timer_cfg.center_align) begin
                if (!down_r && cnt_r >= mod_top) begin
                    down_r <= 1'b1;
                    cnt_r <= cnt_r - 16'h0001;
                end else if (down_r && cnt_r == CNT_ZERO) begin
                    down_r <= 1'b0;
                    cnt_r <= cnt_r + 16'h0001;
                end else if (down_r) begin
                    cnt_r <= cnt_r - 16'h0001;
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end else begin
                down_r <= 1'b0;
                cnt_r <= wrap ? CNT_ZERO : cnt_r + 16'h0001;
            end
        end
    end

    assign period_start = wrap;

    // ==========================================================
    // channels
    // ==========================================================
    logic [NUM_CH-1:0] cap_ev;
    logic [NUM_CH-1:0] match_ev;
    logic [NUM_CH-1:0] pin_drv;
    logic [NUM_CH-1:0] pin_lvl;
    logic [NUM_CH-1:0] own_in;
    logic [NUM_CH-1:0] own_out;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic rise;
            logic fall;
            logic ch_enabled;
            ch_role_t role;

            pin_sync u_pin_sync (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_async(i_channel_pin[g]),
                .o_level(pin_lvl[g]),
                .o_rise(rise),
                .o_fall(fall)
            );

            // with the external clock, the clock pin's channel keeps matches but never owns pin
            assign ch_enabled = enabled && !(i_timer_cfg.clk_src == CS_EXT
                                             && g == EXT_PIN_CH);

            timer_channel u_ch (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_cfg(i_chan_cfg[g]),
                .i_center(i_timer_cfg.center_align),
                .i_enabled(ch_enabled),
                .i_tick(tick),
                .i_count_down(down_r),
                .i_period_start(period_start),
                .i_count(cnt_r),
                .i_pin_rise(rise),
                .i_pin_fall(fall),
                .i_pin_level(pin_lvl[g]),
                .o_role(role),
                .o_pin_nxt(pin_drv[g]),
                .o_capture(cap_ev[g]),
                .o_match()
            );

            // software-timer matches survive on the clock pin channel
            assign match_ev[g] = enabled && tick
                                 && cnt_r == i_chan_cfg[g].value;
            assign own_in[g] = (role == CH_CAPTURE);
            assign own_out[g] = (role == CH_OUTPUT);

            always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    o_captured_value[g*CNT_W +: CNT_W] <= CNT_RESET;
                end else if (cap_ev[g]) begin
                    o_captured_value[g*CNT_W +: CNT_W] <= cnt_r;
                end
            end

            a_capture_store: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                cap_ev[g] |=> o_captured_value[g*CNT_W +: CNT_W]
                              == $past(cnt_r))
                else $error("capture did not store the counter");

            a_capture_role: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                (ch_enabled && !i_timer_cfg.center_align
                 && i_chan_cfg[g].mode == MODE_CAPTURE
                 && i_chan_cfg[g].els != ELS_OFF)
                |=> (o_timer_owns_pin[g] && !o_pin_oe[g]))
                else $error("capture channel did not take its pin");

            a_edge_drive: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                (ch_enabled && !i_timer_cfg.center_align
                 && i_chan_cfg[g].mode[1] && i_chan_cfg[g].els != ELS_OFF)
                |=> o_pin_oe[g])
                else $error("edge pwm channel did not drive its pin");

            a_idle_release: assert property (@(posedge i_ref_clk)
                disable iff (!i_rst_b)
                (i_chan_cfg[g].els == ELS_OFF) |=> !o_timer_owns_pin[g])
                else $error("channel with edge select off kept its pin");
        end
    endgenerate

    // ==========================================================
    // registered outputs
    // ==========================================================
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_channel_pin <= '0;
            o_pin_oe <= '0;
            o_timer_owns_pin <= '0;
        end else begin
            o_channel_pin <= pin_drv;
            o_pin_oe <= own_out;
            o_timer_owns_pin <= own_in | own_out;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_capture_event <= '0;
            o_match_event <= '0;
            o_overflow <= 1'b0;
            o_counter_value <= CNT_RESET;
            o_count_down <= 1'b0;
        end else begin
            o_capture_event <= cap_ev;
            o_match_event <= match_ev;
            o_overflow <= wrap;
            o_counter_value <= cnt_r;
            o_count_down <= down_r;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    a_release_off: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        !enabled |=> o_timer_owns_pin == '0)
        else $error("pin kept while clock source off");

    a_edge_wrap: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (wrap && !i_counter_reset) |=> cnt_r == CNT_ZERO)
        else $error("edge counter did not wrap to zero");

    // mod_top is never zero, so one wrap cannot follow another
    a_wrap_single: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        wrap |=> !wrap)
        else $error("edge counter wrapped on two ticks in a row");

    a_center_turn: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (tick && i_timer_cfg.center_align && !down_r && cnt_r == mod_top
         && !i_counter_reset) |=> down_r)
        else $error("center counter did not turn down at top");

    a_center_floor: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (tick && i_timer_cfg.center_align && down_r && cnt_r == CNT_ZERO
         && !i_counter_reset) |=> (!down_r && cnt_r == 16'h0001))
        else $error("center counter did not turn up at zero");

    a_no_clock: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (!enabled && !i_counter_reset) |=> $stable(cnt_r))
        else $error("counter moved with no clock");

    a_fixed_gate: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (i_timer_cfg.clk_src == CS_FIXED && !i_fixed_tick) |-> !tick)
        else $error("fixed source counted without its tick");

    a_bus_count: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (i_timer_cfg.clk_src == CS_BUS && i_timer_cfg.prescale == PS_RESET
         && !i_timer_cfg.center_align && !i_counter_reset && !wrap)
        |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("bus clock divide-by-one did not count");

    // divide by two: a tick is never followed directly by another
    a_prescale_two: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (tick && i_timer_cfg.clk_src == CS_BUS
         && i_timer_cfg.prescale == 3'h1)
        ##1 (i_timer_cfg.clk_src == CS_BUS && i_timer_cfg.prescale == 3'h1)
        |-> !tick)
        else $error("divide-by-two prescaler ticked twice in a row");

    a_oe_owns: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (o_pin_oe & ~o_timer_owns_pin) == '0)
        else $error("pin driven but not owned");

    a_capture_own: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (|cap_ev) |=> (o_capture_event & ~o_timer_owns_pin) == '0)
        else $error("capture on channel not in capture role");

    a_ext_pin_free: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (i_timer_cfg.clk_src == CS_EXT) |=> !o_timer_owns_pin[EXT_PIN_CH])
        else $error("clock pin channel took its pin");

    a_center_all: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (i_timer_cfg.center_align && enabled && i_chan_cfg[0].els != ELS_OFF
         && !(i_timer_cfg.clk_src == CS_EXT && EXT_PIN_CH == 0))
        |=> o_pin_oe[0])
        else $error("center mode did not drive channel pin");

    c_capture: cover property (@(posedge i_ref_clk) |o_capture_event);
    c_wrap: cover property (@(posedge i_ref_clk) o_overflow);
    c_center: cover property (@(posedge i_ref_clk)
        i_timer_cfg.center_align && down_r);
    c_ext: cover property (@(posedge i_ref_clk)
        i_timer_cfg.clk_src == CS_EXT && tick);
    c_floor: cover property (@(posedge i_ref_clk)
        o_count_down && o_counter_value == CNT_ZERO);
endmodule : timer_pwm_unit

/* timer_pkg.sv */
/*
 * timer_pkg: shared constants and types for the timer pin control block.
 * Assumes a single 50 MHz bus clock and plain control ports, no bus.
 */
package timer_pkg;
    localparam int CNT_W = 16;
    localparam int MAX_CH = 8;
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int SYNC_STAGES = 2;
    // clock_source_select codes
    localparam logic [1:0] CS_NONE = 2'h0;
    localparam logic [1:0] CS_BUS = 2'h1;
    localparam logic [1:0] CS_FIXED = 2'h2;
    localparam logic [1:0] CS_EXT = 2'h3;
    // channel_mode_select codes
    localparam logic [1:0] MODE_CAPTURE = 2'h0;
    localparam logic [1:0] MODE_COMPARE = 2'h1;
    // edge_level_select codes
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_RISE_TOG = 2'h1;
    localparam logic [1:0] ELS_FALL_CLR = 2'h2;
    localparam logic [1:0] ELS_BOTH_SET = 2'h3;
    localparam logic [2:0] PS_RESET = 3'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [7:0] PRE_RESET = 8'h00;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] els;
        logic [CNT_W-1:0] value;
    } chan_cfg_t;

    typedef struct packed {
        logic [1:0] clk_src;
        logic [2:0] prescale;
        logic center_align;
        logic [CNT_W-1:0] modulo;
    } timer_cfg_t;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_CAPTURE = 2'b01,
        CH_OUTPUT = 2'b10
    } ch_role_t;
endpackage : timer_pkg

/* pin_sync.sv */
/*
 * pin_sync: two flip-flop synchroniser with edge detection behind it.
 * Assumes an asynchronous input and the bus clock.
 */
`timescale 1ns/1ps
module pin_sync import timer_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_async,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // meta_r feeds only sync_r
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_rise = sync_r & ~last_r;
    assign o_fall = ~sync_r & last_r;
endmodule : pin_sync

/* timer_channel.sv */
/*
 * timer_channel: one channel's pin logic (capture, compare, PWM).
 * Assumes counter, direction and period start come from the parent.
 */
`timescale 1ns/1ps
module timer_channel import timer_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire chan_cfg_t i_cfg,
    input wire logic i_center,
    input wire logic i_enabled,
    input wire logic i_tick,
    input wire logic i_count_down,
    input wire logic i_period_start,
    input wire logic [CNT_W-1:0] i_count,
    input wire logic i_pin_rise,
    input wire logic i_pin_fall,
    input wire logic i_pin_level,
    output ch_role_t o_role,
    output logic o_pin_nxt,
    output logic o_capture,
    output logic o_match
);
    logic pin_r;
    logic match;
    logic [1:0] prev_mode_r;
    logic [CNT_W-1:0] next_count;
    logic edge_hit;

    // pin handed back to gpio when disabled or no clock
    always_comb begin
        if (i_cfg.els == ELS_OFF || !i_enabled) begin
            o_role = CH_IDLE;
        end else if (i_center) begin
            o_role = CH_OUTPUT;
        end else if (i_cfg.mode == MODE_CAPTURE) begin
            o_role = CH_CAPTURE;
        end else begin
            o_role = CH_OUTPUT;
        end
    end

    assign match = i_tick && (i_count == i_cfg.value);
    assign o_match = match && i_enabled;

    // edge pwm acts on the count about to be entered, so the pulse
    // covers counts 0 to value-1 and not one count more
    assign next_count = i_period_start ? CNT_ZERO : i_count + 16'h0001;
    assign edge_hit = i_tick && (next_count == i_cfg.value);

    // capture edge choice
    always_comb begin
        o_capture = 1'b0;
        if (o_role == CH_CAPTURE) begin
            case (i_cfg.els)
                ELS_RISE_TOG: o_capture = i_pin_rise;
                ELS_FALL_CLR: o_capture = i_pin_fall;
                ELS_BOTH_SET: o_capture = i_pin_rise | i_pin_fall;
                default: o_capture = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_mode_r <= MODE_CAPTURE;
        end else begin
            prev_mode_r <= i_cfg.mode;
        end
    end

    // pin drive state
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_r <= 1'b0;
        end else if (o_role != CH_OUTPUT) begin
            // track the pin so toggle starts from its level
            pin_r <= i_pin_level;
        end else if (i_center) begin
            if (match) begin
                pin_r <= i_count_down ^ i_cfg.els[0];
            end
        end else if (i_cfg.mode[1]) begin
            if (edge_hit) begin
                pin_r <= i_cfg.els[0];
            end else if (i_period_start) begin
                pin_r <= ~i_cfg.els[0];
            end
        end else if (match) begin
            case (i_cfg.els)
                ELS_RISE_TOG: pin_r <= ~pin_r;
                ELS_FALL_CLR: pin_r <= 1'b0;
                ELS_BOTH_SET: pin_r <= 1'b1;
                default: pin_r <= pin_r;
            endcase
        end
    end

    assign o_pin_nxt = pin_r;

    a_toggle_flip: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_b)
        (o_role == CH_OUTPUT && !i_center && i_cfg.mode == MODE_COMPARE
         && i_cfg.els == ELS_RISE_TOG && match && $past(o_role) == CH_OUTPUT
         && prev_mode_r == MODE_COMPARE)
        |=> pin_r != $past(pin_r))
        else $error("toggle compare did not flip pin");
endmodule : timer_channel

/* pin_model.sv */
/*
 * pin_model: the world outside the timer's channel pins and clock pin.
 * Assumes the bench sets the outside pin levels and starts the clock.
 */
`timescale 1ns/1ps
module pin_model import timer_pkg::*; #(
    parameter int NUM_CH = 4
) (
    input wire logic i_ref_clk,
    input wire logic i_ext_run,
    input wire logic [NUM_CH-1:0] i_level,
    input wire logic [NUM_CH-1:0] i_drive,
    input wire logic [NUM_CH-1:0] i_oe,
    output logic [NUM_CH-1:0] o_pin,
    output logic o_ext_clk
);
    int ph = 0;

    // ==========================================================
    // pad level
    // the timer wins where it drives; elsewhere the outside level
    assign o_pin = (i_oe & i_drive) | (~i_oe & i_level);

    // ==========================================================
    // external count clock
    // one sixth of the bus rate keeps well under the quarter limit;
    // it stands low while not in use
    always @(posedge i_ref_clk) begin
        if (!i_ext_run) begin
            ph <= 0;
            o_ext_clk <= 1'b0;
        end else begin
            ph <= (ph == 5) ? 0 : ph + 1;
            o_ext_clk <= (ph < 3);
        end
    end
endmodule : pin_model

/* tb.sv */
/*
 * tb: self-checking bench for timer_pwm_unit with four channels.
 * Assumes timer_pkg and the pin_model partner; counts whole periods
 * so pipeline latency does not move the expected figures.
 */
`timescale 1ns/1ps
module tb;
    import timer_pkg::*;
    localparam int N = 4;
    logic i_ref_clk = 1'b0;
    logic i_rst_b = 1'b0;
    timer_cfg_t tcfg = '0;
    chan_cfg_t [N-1:0] ccfg = '0;
    logic fix_en = 1'b0, fix_tick = 1'b0, cnt_rst = 1'b0;
    logic ext_run = 1'b0, ext_clk;
    logic [N-1:0] lvl = '0, pin_in, pin_out, oe, owns, cap, mat;
    logic ovf, dn;
    int bad_count = 0, comparisons = 0, cyc = 0, fix_ph = 0, novf, ndn;
    int hi[N], tog[N], nmat[N], ncap[N];
    int vals[$];
    int v;

    timer_pwm_unit #(.NUM_CH(N), .EXT_PIN_CH(0)) timer_pwm_unit_inst (
        .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_timer_cfg(tcfg),
        .i_chan_cfg(ccfg), .i_fixed_tick(fix_tick),
        .i_ext_count_clock(ext_clk), .i_counter_reset(cnt_rst),
        .i_channel_pin(pin_in), .o_channel_pin(pin_out), .o_pin_oe(oe),
        .o_timer_owns_pin(owns), .o_counter_value(), .o_count_down(dn),
        .o_overflow(ovf), .o_capture_event(cap), .o_match_event(mat),
        .o_captured_value());

    pin_model #(.NUM_CH(N)) pin_model_inst (
        .i_ref_clk(i_ref_clk), .i_ext_run(ext_run), .i_level(lvl),
        .i_drive(pin_out), .i_oe(oe), .o_pin(pin_in),
        .o_ext_clk(ext_clk));

    // ==========================================================
    // clock, fixed-rate tick and run limit
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end

    always @(negedge i_ref_clk) begin
        fix_ph <= (fix_ph == 2) ? 0 : fix_ph + 1;
        fix_tick <= fix_en && (fix_ph == 0);
    end

    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ==========================================================
    // helpers
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %0d seen %0d", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic chan(input int ch, input logic [1:0] mode,
                        input logic [1:0] els, input int val);
        ccfg[ch].mode = mode;
        ccfg[ch].els = els;
        ccfg[ch].value = 16'(val);
    endtask : chan

    // reset the counter, let the pipeline settle, clear the tallies
    task automatic setup(input logic [1:0] src, input logic [2:0] ps,
                         input logic ca, input int modv);
        @(negedge i_ref_clk);
        tcfg.clk_src = src;
        tcfg.prescale = ps;
        tcfg.center_align = ca;
        tcfg.modulo = 16'(modv);
        cnt_rst = 1'b1;
        @(negedge i_ref_clk);
        cnt_rst = 1'b0;
        repeat (12) @(negedge i_ref_clk);
        novf = 0;
        ndn = 0;
        for (int c = 0; c < N; c++) begin
            hi[c] = 0;
            tog[c] = 0;
            nmat[c] = 0;
            ncap[c] = 0;
        end
    endtask : setup

    task automatic measure(input int n);
        logic [N-1:0] prev;
        prev = pin_out;
        repeat (n) begin
            @(negedge i_ref_clk);
            novf += (ovf === 1'b1);
            ndn += (dn === 1'b1);
            for (int c = 0; c < N; c++) begin
                hi[c] += (pin_out[c] === 1'b1);
                tog[c] += (pin_out[c] !== prev[c]);
                nmat[c] += (mat[c] === 1'b1);
                ncap[c] += (cap[c] === 1'b1);
            end
            prev = pin_out;
        end
    endtask : measure

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(40673));
        repeat (8) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        @(negedge i_ref_clk);
        check("owns_at_reset", 32'(owns), 0);
        check("pin_at_reset", 32'(pin_out), 0);
        // sources none, bus, fixed tick every third cycle; modulo 8
        chan(0, 2'h2, ELS_FALL_CLR, 5);
        fix_en = 1'b1;
        for (int s = 0; s < 3; s++) begin
            setup(s[1:0], 3'h0, 1'b0, 8);
            measure(54);
            check("overflows", novf, (s == 0) ? 0 : (s == 1) ? 6 : 2);
            check("owns_by_source", 32'(owns[0]), (s != 0));
        end
        for (int p = 0; p < 8; p++) begin
            setup(CS_BUS, p[2:0], 1'b0, 1);
            measure(512);
            check("prescaled_overflows", novf, 256 >> p);
        end
        // edge pwm, high-true on channel 1, low-true on channel 3
        for (int k = 0; k < 3; k++) vals.push_back($urandom_range(8, 1));
        foreach (vals[k]) begin
            chan(0, 2'h2, ELS_FALL_CLR, vals[k]);
            chan(2, 2'h3, ELS_RISE_TOG, vals[k]);
            setup(CS_BUS, 3'h0, 1'b0, 8);
            measure(36);
            check("edge_high_ch1", hi[0], 4 * vals[k]);
            check("edge_high_ch3", hi[2], 4 * (9 - vals[k]));
            check("edge_oe", 32'(oe[0] & oe[2]), 1);
        end
        // center pwm; channel 1 mode bits are ignored there
        for (int k = 0; k < 3; k++) begin
            v = $urandom_range(7, 1);
            chan(0, MODE_CAPTURE, ELS_FALL_CLR, v);
            chan(2, MODE_COMPARE, ELS_RISE_TOG, v);
            setup(CS_BUS, 3'h0, 1'b1, 8);
            measure(64);
            check("center_high_ch1", hi[0], 8 * v);
            check("center_high_ch3", hi[2], 64 - 8 * v);
            check("center_down", ndn, 32);
            check("center_oe", 32'({oe[0], oe[2], owns[1]}), 3'h6);
        end
        // toggle must start from the level the released pin showed
        lvl[0] = 1'b1;
        chan(0, MODE_COMPARE, ELS_RISE_TOG, 8);
        chan(2, MODE_COMPARE, ELS_OFF, 0);
        setup(CS_NONE, 3'h0, 1'b0, 8);
        tcfg.clk_src = CS_BUS;
        repeat (4) @(negedge i_ref_clk);
        check("toggle_start", 32'({oe[0], pin_out[0]}), 3);
        measure(36);
        check("toggles", tog[0], 4);
        for (int e = 2; e < 4; e++) begin
            chan(0, MODE_COMPARE, e[1:0], 3);
            setup(CS_BUS, 3'h0, 1'b0, 8);
            measure(36);
            check("clear_set_high", hi[0], (e == 3) ? 36 : 0);
        end
        // capture on channel 2, pulses of six cycles
        for (int e = 1; e < 4; e++) begin
            chan(1, MODE_CAPTURE, e[1:0], 0);
            setup(CS_BUS, 3'h0, 1'b0, 8);
            repeat (8) begin
                lvl[1] = ~lvl[1];
                measure(6);
            end
            check("captures", ncap[1], (e == 3) ? 8 : 4);
            check("capture_pin", 32'({owns[1], oe[1]}), 2);
        end
        // channel 1 as a pure software timer on the clock pin
        chan(0, MODE_COMPARE, ELS_OFF, 3);
        chan(1, MODE_CAPTURE, ELS_OFF, 0);
        ext_run = 1'b1;
        setup(CS_EXT, 3'h0, 1'b0, 8);
        measure(108);
        check("ext_matches", nmat[0], 2);
        check("ext_overflows", novf, 2);
        check("ext_pin_free", 32'(owns[0]), 0);
        wrap_up();
    end
endmodule : tb
